/* File: verilog/mss_defs.svh */
// Register offsets, field positions, reset values and timing figures of the stage sequencer
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

`define MSS_ADDR_W        12
`define MSS_ADDR_MODE     12'h000
`define MSS_ADDR_LIMIT    12'h004
`define MSS_ADDR_FBSEL    12'h008
`define MSS_ADDR_STATUS   12'h00C
`define MSS_ADDR_SET_BASE 12'h010
`define MSS_ADDR_DUR_BASE 12'h030
`define MSS_NUM_STAGES    7

`define MSS_MODE_UNITS_LSB 0
`define MSS_MODE_TENS_LSB  4
`define MSS_MODE_HUND_LSB  8
`define MSS_MODE_THOU_LSB  12
`define MSS_SET_SRC_LSB    0
`define MSS_SET_DIR_LSB    4
`define MSS_SET_ACC_LSB    8
`define MSS_LIM_LOW_LSB    0
`define MSS_LIM_UP_LSB     16
`define MSS_ST_STAGE_LSB   4
`define MSS_ST_SAVED_LSB   8
`define MSS_ST_USEREC_LSB  9
`define MSS_ST_ELAPS_LSB   16

`define MSS_DUR_RST       13'h0014
`define MSS_DUR_MAX       13'h1964
`define MSS_LOWER_RST     16'h0000
`define MSS_UPPER_RST     16'h1388
`define MSS_FBSEL_RST     3'h1

`define MSS_DIR_FWD       2'h0
`define MSS_DIR_REV       2'h1
`define MSS_DIR_FOLLOW    2'h2

`define MSS_CLK_MHZ       125
`define MSS_SECOND_MS     1000
`define MSS_PULSE_MS      500
`define MSS_MIN_SECONDS   6'h3B
`define MSS_CNT_W         27

`endif

/* File: verilog/mss_pkg.sv */
// Types shared by the stage sequencer modules
package mss_pkg;

    typedef logic [15:0] mss_freq_t;

    typedef enum logic [1:0] {
        MSS_IDLE = 2'h0,
        MSS_RUN  = 2'h1,
        MSS_HOLD = 2'h3
    } mss_state_e;

    typedef struct packed {
        logic       thou;
        logic       hund;
        logic [1:0] tens;
        logic [1:0] units;
    } mss_mode_s;

    typedef struct packed {
        logic [1:0] acc;
        logic [1:0] dir;
        logic [1:0] src;
    } mss_stage_cfg_s;

    typedef struct packed {
        logic run;
        logic stop;
        logic fault;
        logic power_loss;
        logic pause;
        logic disable_seq;
        logic clear;
        logic forward_run_terminal;
        logic reverse_run_terminal;
    } mss_term_s;

    typedef struct packed {
        mss_freq_t  freq;
        logic       dir;
        logic [1:0] acc_set;
        logic       closed_loop;
        logic [2:0] fb_sel;
        logic       active;
    } mss_drive_s;

    typedef struct packed {
        logic [26:0] pre;
        logic [5:0]  sec;
        logic        tick;
    } mss_tick_s;

endpackage

/* File: verilog/mss_tick.sv */
// Time-base tick of the stage sequencer: one pulse per second or per minute
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_tick
    import mss_pkg::*;
#(
    parameter int SEC_CYCLES = `MSS_SECOND_MS * `MSS_CLK_MHZ * 1000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic en,
    input  wire logic base_min,
    output logic      unit_tick
);
    mss_tick_s r;
    mss_tick_s n;
    logic      sec_end;

    // Partial units are dropped when counting stops; resume loses under one unit
    always_comb begin
        n       = r;
        n.tick  = 1'b0;
        sec_end = (r.pre == 27'(SEC_CYCLES - 1));
        if (!en) begin
            n.pre = '0;
            n.sec = '0;
        end else if (sec_end) begin
            n.pre = '0;
            if (!base_min) begin
                n.tick = 1'b1;
                n.sec  = '0;
            end else if (r.sec == `MSS_MIN_SECONDS) begin
                n.tick = 1'b1;
                n.sec  = '0;
            end else begin
                n.sec = r.sec + 6'h01;
            end
        end else begin
            n.pre = r.pre + 27'h0000001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign unit_tick = r.tick;

endmodule

/* File: verilog/mss_sequencer.sv */
// Seven-stage time-based speed sequencer with APB registers
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_sequencer
    import mss_pkg::*;
#(
    parameter int SEC_CYCLES   = `MSS_SECOND_MS * `MSS_CLK_MHZ * 1000,
    parameter int PULSE_CYCLES = `MSS_PULSE_MS * `MSS_CLK_MHZ * 1000
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`MSS_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire mss_term_s               term,
    input  wire mss_freq_t [6:0]         preset_frequency,
    input  wire mss_freq_t [6:0]         closed_loop_preset,
    input  wire mss_freq_t               main_frequency_source,
    input  wire mss_freq_t               closed_loop_reference,
    input  wire mss_freq_t               output_frequency,
    output mss_drive_s                   drive,
    output logic [2:0]                   stage_index,
    output logic                         cycle_done_pulse
);
    typedef struct packed {
        mss_state_e              state;
        mss_mode_s               mode;
        mss_freq_t               lower;
        mss_freq_t               upper;
        logic [2:0]              fbsel;
        mss_stage_cfg_s [6:0]    cfg;
        logic [6:0][12:0]        dur;
        logic [2:0]              stage;
        logic [12:0]             elapsed;
        logic                    saved;
        logic                    use_rec;
        mss_freq_t               rec_freq;
        logic [`MSS_CNT_W-1:0]   pulse_cnt;
        logic                    pulse_o;
        mss_drive_s              drive;
        logic                    pready;
        logic [31:0]             prdata;
        logic                    pslverr;
    } mss_core_s;

    mss_core_s            r;
    mss_core_s            n;
    logic                 unit_tick;
    logic                 access;
    logic [`MSS_ADDR_W-1:0] set_off;
    logic [`MSS_ADDR_W-1:0] dur_off;
    logic                 set_hit;
    logic                 dur_hit;
    logic                 end_cyc;
    logic                 start_ok;
    logic                 keep_dir;
    logic [3:0]           first_all;
    logic [3:0]           nxt_stage;
    logic                 halt_req;
    mss_stage_cfg_s       cur;

    function automatic logic [3:0] find_stage(input logic [3:0] from, input logic [6:0][12:0] d);
        logic [3:0] res;
        res = 4'h0;
        for (int i = 6; i >= 0; i--) begin
            if (4'(i) >= from && d[i] != 13'h0000) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction

    function automatic mss_freq_t clamp(input mss_freq_t f, input mss_freq_t lo, input mss_freq_t hi);
        mss_freq_t res;
        res = f;
        if (f < lo) begin
            res = lo;
        end else if (f > hi) begin
            res = hi;
        end
        return res;
    endfunction

    function automatic logic in_block(input logic [`MSS_ADDR_W-1:0] off);
        return off[1:0] == 2'h0 && off[`MSS_ADDR_W-1:2] < 10'(`MSS_NUM_STAGES);
    endfunction

    mss_tick #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_tick (
        .pclk      (pclk),
        .presetn   (presetn),
        .en        (r.state == MSS_RUN && !term.pause),
        .base_min  (r.mode.thou),
        .unit_tick (unit_tick)
    );

    always_comb begin
        n         = r;
        access    = psel && penable;
        set_off   = paddr - `MSS_ADDR_SET_BASE;
        dur_off   = paddr - `MSS_ADDR_DUR_BASE;
        set_hit   = paddr >= `MSS_ADDR_SET_BASE && in_block(set_off);
        dur_hit   = paddr >= `MSS_ADDR_DUR_BASE && in_block(dur_off);
        end_cyc   = 1'b0;
        start_ok  = term.run && !term.stop && !term.fault && !term.power_loss;
        keep_dir  = 1'b0;
        halt_req  = term.stop || term.fault || term.power_loss;
        first_all = find_stage(4'h0, r.dur);
        nxt_stage = find_stage({1'b0, r.stage} + 4'h1, r.dur);

        // One wait state: read data is prepared while pready is low
        n.pready = access && !r.pready;
        if (access && !r.pready) begin
            n.prdata  = 32'h00000000;
            n.pslverr = 1'b0;
            if (paddr == `MSS_ADDR_MODE) begin
                n.prdata = (32'(r.mode.units) << `MSS_MODE_UNITS_LSB) | (32'(r.mode.tens) << `MSS_MODE_TENS_LSB)
                         | (32'(r.mode.hund) << `MSS_MODE_HUND_LSB) | (32'(r.mode.thou) << `MSS_MODE_THOU_LSB);
            end else if (paddr == `MSS_ADDR_LIMIT) begin
                n.prdata = (32'(r.lower) << `MSS_LIM_LOW_LSB) | (32'(r.upper) << `MSS_LIM_UP_LSB);
            end else if (paddr == `MSS_ADDR_FBSEL) begin
                n.prdata = 32'(r.fbsel);
            end else if (paddr == `MSS_ADDR_STATUS) begin
                n.prdata = 32'(r.state) | (32'(r.stage) << `MSS_ST_STAGE_LSB) | (32'(r.saved) << `MSS_ST_SAVED_LSB)
                         | (32'(r.use_rec) << `MSS_ST_USEREC_LSB) | (32'(r.elapsed) << `MSS_ST_ELAPS_LSB);
            end else if (set_hit) begin
                cur      = r.cfg[set_off[4:2]];
                n.prdata = (32'(cur.src) << `MSS_SET_SRC_LSB) | (32'(cur.dir) << `MSS_SET_DIR_LSB)
                         | (32'(cur.acc) << `MSS_SET_ACC_LSB);
            end else if (dur_hit) begin
                n.prdata = 32'(r.dur[dur_off[4:2]]);
            end else begin
                n.pslverr = 1'b1;
            end
        end
        cur = r.cfg[r.stage];

        // Writes land at the completing edge only
        if (access && r.pready && pwrite && !r.pslverr) begin
            if (paddr == `MSS_ADDR_MODE) begin
                n.mode.units = pwdata[`MSS_MODE_UNITS_LSB +: 2];
                n.mode.tens  = pwdata[`MSS_MODE_TENS_LSB +: 2] == 2'h3 ? 2'h2 : pwdata[`MSS_MODE_TENS_LSB +: 2];
                n.mode.hund  = pwdata[`MSS_MODE_HUND_LSB];
                n.mode.thou  = pwdata[`MSS_MODE_THOU_LSB];
            end else if (paddr == `MSS_ADDR_LIMIT) begin
                n.lower = pwdata[`MSS_LIM_LOW_LSB +: 16];
                n.upper = pwdata[`MSS_LIM_UP_LSB +: 16];
            end else if (paddr == `MSS_ADDR_FBSEL) begin
                n.fbsel = pwdata[2:0];
            end else if (set_hit) begin
                // Direction digit above 2 is out of range and folds to follow
                n.cfg[set_off[4:2]].src = pwdata[`MSS_SET_SRC_LSB +: 2];
                n.cfg[set_off[4:2]].dir = pwdata[`MSS_SET_DIR_LSB +: 2] == 2'h3 ? `MSS_DIR_FOLLOW
                                        : pwdata[`MSS_SET_DIR_LSB +: 2];
                n.cfg[set_off[4:2]].acc = pwdata[`MSS_SET_ACC_LSB +: 2];
            end else if (dur_hit) begin
                n.dur[dur_off[4:2]] = pwdata > 32'(`MSS_DUR_MAX) ? `MSS_DUR_MAX : pwdata[12:0];
            end
        end

        if (r.pulse_cnt != '0) begin
            n.pulse_cnt = r.pulse_cnt - `MSS_CNT_W'(1);
        end

        if (term.disable_seq || r.mode.units == 2'h0) begin
            n.state = MSS_IDLE;
        end else begin
            unique case (r.state)
                MSS_IDLE: begin
                    if (start_ok && (r.saved || first_all[3])) begin
                        n.state = MSS_RUN;
                        if (!r.saved) begin
                            n.stage   = first_all[2:0];
                            n.elapsed = 13'h0000;
                            n.use_rec = 1'b0;
                        end
                    end
                end
                MSS_RUN: begin
                    if (term.power_loss) begin
                        n.state    = MSS_IDLE;
                        n.saved    = r.mode.hund && r.mode.tens != 2'h0;
                        n.use_rec  = r.mode.hund && r.mode.tens == 2'h2;
                        n.rec_freq = output_frequency;
                    end else if (term.stop || term.fault) begin
                        n.state    = MSS_IDLE;
                        n.saved    = r.mode.tens != 2'h0;
                        n.use_rec  = r.mode.tens == 2'h2;
                        n.rec_freq = output_frequency;
                    end else if (r.dur[r.stage] == 13'h0000 || (unit_tick && !term.pause
                                 && r.elapsed + 13'h0001 >= r.dur[r.stage])) begin
                        n.elapsed = 13'h0000;
                        n.use_rec = 1'b0;
                        if (nxt_stage[3]) begin
                            n.stage = nxt_stage[2:0];
                        end else begin
                            end_cyc     = 1'b1;
                            n.pulse_cnt = `MSS_CNT_W'(PULSE_CYCLES);
                            n.saved     = 1'b0;
                            if (r.mode.units == 2'h1) begin
                                n.state = MSS_IDLE;
                            end else if (r.mode.units == 2'h2) begin
                                n.state = MSS_HOLD;
                            end else begin
                                n.stage = first_all[2:0];
                                n.state = first_all[3] ? MSS_RUN : MSS_IDLE;
                            end
                        end
                    end else if (unit_tick && !term.pause) begin
                        n.elapsed = r.elapsed + 13'h0001;
                    end
                end
                MSS_HOLD: begin
                    if (halt_req) begin
                        n.state = MSS_IDLE;
                    end
                end
                default: begin
                    n.state = MSS_IDLE;
                end
            endcase
        end

        // Clear overrides whatever was just retained
        if (term.clear) begin
            n.saved   = 1'b0;
            n.use_rec = 1'b0;
            n.elapsed = 13'h0000;
            n.stage   = 3'h0;
        end

        // Drive reference is refreshed only while stepping; hold freezes it
        n.drive.fb_sel = n.fbsel;
        if (n.state == MSS_IDLE) begin
            n.drive.active = 1'b0;
        end else if (n.state == MSS_RUN) begin
            cur                 = n.cfg[n.stage];
            n.drive.active      = 1'b1;
            n.drive.acc_set     = cur.acc;
            n.drive.closed_loop = cur.src[1];
            if (n.use_rec) begin
                n.drive.freq = n.rec_freq;
            end else begin
                unique case (cur.src)
                    2'h0: n.drive.freq = clamp(preset_frequency[n.stage], n.lower, n.upper);
                    2'h1: n.drive.freq = main_frequency_source;
                    2'h2: n.drive.freq = closed_loop_preset[n.stage];
                    2'h3: n.drive.freq = closed_loop_reference;
                endcase
            end
            if (cur.dir == `MSS_DIR_FOLLOW) begin
                if (term.forward_run_terminal) begin
                    n.drive.dir = 1'b0;
                end else if (term.reverse_run_terminal) begin
                    n.drive.dir = 1'b1;
                end else begin
                    keep_dir = 1'b1;
                end
            end else begin
                n.drive.dir = cur.dir == `MSS_DIR_REV;
            end
        end
        n.pulse_o = n.pulse_cnt != '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.state <= MSS_IDLE;
            r.lower <= `MSS_LOWER_RST;
            r.upper <= `MSS_UPPER_RST;
            r.fbsel <= `MSS_FBSEL_RST;
            r.dur   <= {`MSS_NUM_STAGES{`MSS_DUR_RST}};
        end else begin
            r <= n;
        end
    end

    assign prdata           = r.prdata;
    assign pready           = r.pready;
    assign pslverr          = r.pslverr;
    assign drive            = r.drive;
    assign stage_index      = r.stage;
    assign cycle_done_pulse = r.pulse_o;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mode_off_idle: assert property (r.mode.units == 2'h0 |=> r.state == MSS_IDLE)
        else $error("sequencer ran with mode off");
    a_single_stop: assert property (end_cyc && r.mode.units == 2'h1 && !term.clear |=> r.state == MSS_IDLE
                                    && !r.drive.active)
        else $error("single cycle did not stop");
    a_hold_final: assert property (end_cyc && r.mode.units == 2'h2 |=> r.state == MSS_HOLD ##1
                                   (halt_req || $stable(r.drive.freq)))
        else $error("hold did not keep final stage");
    a_loop_again: assert property (end_cyc && r.mode.units == 2'h3 && !term.clear
                                   |=> r.state == MSS_RUN && r.elapsed == 13'h0000)
        else $error("continuous mode did not restart");
    a_restart_first: assert property (r.state == MSS_IDLE && start_ok && !r.saved && first_all[3]
                                      && !term.disable_seq && r.mode.units != 2'h0 && !term.clear
                                      |=> r.stage == $past(first_all[2:0]))
        else $error("restart not from first stage");
    a_stop_keeps: assert property (r.state == MSS_RUN && (term.stop || term.fault) && !term.power_loss
                                   && r.mode.tens == 2'h1 && !term.clear && !term.disable_seq && r.mode.units != 2'h0
                                   |=> r.saved && !r.use_rec && r.elapsed == $past(r.elapsed))
        else $error("stop did not keep stage time");
    a_freq_record: assert property (r.state == MSS_RUN && term.stop && !term.power_loss && r.mode.tens == 2'h2
                                    && !term.clear && !term.disable_seq && r.mode.units != 2'h0
                                    |=> r.use_rec && r.rec_freq == $past(output_frequency))
        else $error("output frequency not recorded");
    a_pwr_discard: assert property (r.state == MSS_RUN && term.power_loss && !r.mode.hund && !term.disable_seq
                                    && r.mode.units != 2'h0 |=> !r.saved)
        else $error("state kept over power loss");
    a_skip_zero: assert property (r.state == MSS_RUN && r.dur[r.stage] == 13'h0000 && !halt_req && !term.clear
                                  && !term.disable_seq && r.mode.units != 2'h0 && r.mode.units != 2'h3
                                  |=> r.state != MSS_RUN || r.stage != $past(r.stage))
        else $error("zero-length stage executed");
    a_pulse_width: assert property (end_cyc |=> r.pulse_o && r.pulse_cnt == `MSS_CNT_W'(PULSE_CYCLES))
        else $error("completion pulse not started");
    a_dir_hold: assert property (keep_dir |=> r.drive.dir == $past(r.drive.dir))
        else $error("direction changed without terminal");
    a_pause_freeze: assert property (r.state == MSS_RUN && term.pause && r.dur[r.stage] != 13'h0000
                                     && !halt_req && !term.clear |=> r.elapsed == $past(r.elapsed))
        else $error("stage time advanced in pause");
    a_freq_limit: assert property (r.drive.active && r.state == MSS_RUN && r.cfg[r.stage].src == 2'h0
                                   && !r.use_rec |-> r.drive.freq >= r.lower && r.drive.freq <= r.upper)
        else $error("preset frequency outside limits");

    c_cycle_loop: cover property (end_cyc && r.mode.units == 2'h3);
    c_hold_entry: cover property (r.state == MSS_RUN ##1 r.state == MSS_HOLD);
    c_resume: cover property (r.state == MSS_IDLE && r.saved && start_ok);
    c_skip: cover property (r.state == MSS_RUN && r.dur[r.stage] == 13'h0000);

endmodule

/* File: testbench/mss_ramp_model.sv */
// Ramp model standing in for the drive behind the sequencer
`timescale 1ns/1ps
module mss_ramp_model
    import mss_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire mss_drive_s drive,
    output mss_freq_t       output_frequency
);
    mss_freq_t target;
    // Ramps down to zero when idle, so a recorded value is never stale
    assign target = drive.active ? drive.freq : 16'h0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_frequency <= 16'h0000;
        end else if (output_frequency < target) begin
            output_frequency <= output_frequency + 16'h0001;
        end else if (output_frequency > target) begin
            output_frequency <= output_frequency - 16'h0001;
        end
    end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench of the stage sequencer
`timescale 1ns/1ps
module tb
    import mss_pkg::*;
;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, done_p;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata;
    mss_term_s        term;
    mss_freq_t [6:0]  pf, clp;
    mss_freq_t        mainf, clref, ofreq;
    mss_drive_s       drive;
    logic [2:0]       stage_index;
    logic [32:0]      expq[$];
    int               err_count, n_checks, seed, i, m;
    localparam int    PULSE = 5;
    mss_sequencer #(.SEC_CYCLES(10), .PULSE_CYCLES(PULSE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .term(term), .preset_frequency(pf), .closed_loop_preset(clp),
        .main_frequency_source(mainf), .closed_loop_reference(clref), .output_frequency(ofreq),
        .drive(drive), .stage_index(stage_index), .cycle_done_pulse(done_p));
    mss_ramp_model ramp (.pclk(pclk), .presetn(presetn), .drive(drive), .output_frequency(ofreq));
    task check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        if (!w) expq.push_back(exp);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // No fixed wait assumed; only the watchdog ends a stuck access
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task pulse_term(input int b);
        @(posedge pclk);
        term[b] <= 1'b1;
        @(posedge pclk);
        term[b] <= 1'b0;
    endtask
    task test_done;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Read answers are matched in order against the notes of the master
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, expq.pop_front());
    end
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #400000;
        err_count++;
        test_done;
    end
    initial begin
        seed = 59; err_count = 0; n_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h00000000; term = '0;
        // Random presets stay inside the reset limits so no clamping applies
        for (i = 0; i < 7; i++) begin
            pf[i] = 16'($unsigned($random(seed)) % 32'h00001388);
            clp[i] = 16'($random(seed));
        end
        mainf = 16'($random(seed)); clref = 16'($random(seed));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 33'h000000000);
        apb(1'b0, 12'h004, 32'h0, 33'h013880000);
        apb(1'b0, 12'h008, 32'h0, 33'h000000001);
        apb(1'b0, 12'h030, 32'h0, 33'h000000014);
        apb(1'b0, 12'hFFC, 32'h0, 33'h100000000);
        apb(1'b1, 12'h034, 32'h1FFF, 33'h0);
        apb(1'b0, 12'h034, 32'h0, 33'h000001964);
        $display("register test done");
        pulse_term(8);
        repeat (3) @(posedge pclk);
        check(drive.active, 1'b0);
        for (i = 0; i < 7; i++) apb(1'b1, 12'(32'h030 + 4 * i), (i == 0 || i == 2) ? 32'h1 : 32'h0, 33'h0);
        for (m = 1; m < 4; m++) begin
            apb(1'b1, 12'h000, 32'(m), 33'h0);
            pulse_term(8);
            for (i = 0; i < 20 && drive.active !== 1'b1; i++) @(posedge pclk);
            check(stage_index, 3'h0);
            check(drive.freq, pf[0]);
            for (i = 0; i < 200 && stage_index === 3'h0; i++) @(posedge pclk);
            check(stage_index, 3'h2);
            for (i = 0; i < 200 && done_p !== 1'b1; i++) @(posedge pclk);
            check(done_p, 1'b1);
            // Count the cycles the pulse stands
            for (i = 1; i < 20 && done_p === 1'b1; i++) @(posedge pclk);
            check(i - 1, PULSE);
            check(drive.active, m != 1);
            if (m == 2) check(drive.freq, pf[2]);
            if (m == 3) check(stage_index, 3'h0);
            pulse_term(7);
            repeat (2) @(posedge pclk);
            check(drive.active, 1'b0);
            $display("mode %0d test done", m);
        end
        // Main reference, ramp set 3, direction digit 3 folds to follow
        apb(1'b1, 12'h010, 32'h331, 33'h0);
        apb(1'b0, 12'h010, 32'h0, 33'h000000321);
        apb(1'b1, 12'h008, 32'h5, 33'h0);
        apb(1'b1, 12'h030, 32'h3, 33'h0);
        apb(1'b1, 12'h000, 32'h11, 33'h0);
        @(posedge pclk);
        term[0] <= 1'b1;
        pulse_term(8);
        @(posedge pclk);
        term[0] <= 1'b0;
        check(drive.freq, mainf);
        check(drive.dir, 1'b1);
        check(drive.acc_set, 2'h3);
        check(drive.fb_sel, 3'h5);
        check(drive.closed_loop, 1'b0);
        repeat (3) @(posedge pclk);
        check(drive.dir, 1'b1);
        repeat (10) @(posedge pclk);
        pulse_term(7);
        apb(1'b0, 12'h00C, 32'h0, 33'h000010100);
        pulse_term(8);
        apb(1'b0, 12'h00C, 32'h0, 33'h000010101);
        term[4] <= 1'b1;
        repeat (30) @(posedge pclk);
        apb(1'b0, 12'h00C, 32'h0, 33'h000010101);
        pulse_term(2);
        apb(1'b0, 12'h00C, 32'h0, 33'h000000001);
        pulse_term(3);
        repeat (2) @(posedge pclk);
        check(drive.active, 1'b0);
        term[4] <= 1'b0;
        // Minutes base: no unit elapses in a few dozen cycles
        apb(1'b1, 12'h000, 32'h1023, 33'h0);
        pulse_term(8);
        repeat (14) @(posedge pclk);
        pulse_term(7);
        m = ofreq;
        pulse_term(8);
        @(posedge pclk);
        check(drive.freq, m);
        apb(1'b0, 12'h00C, 32'h0, 33'h000000301);
        pulse_term(7);
        $display("terminal test done");
        test_done;
    end
endmodule
